// ---- hdl/mts_map.vh ----
// Purpose: Constants of the multichannel temperature sequencer
// Assumes: Included by bare name from the design files
// Notes:   Offsets are byte addresses of the plain register port
//
// What this block does
// - Capture address pins once after power-up
// - Standby pin low stops, high runs
// - Standby keeps results and limits unchanged
// - Alarm output only pulls low
// - Data pin open drain, clock only input
// - Per-channel data, high and low limits
// - Each result is eight bits
// - Integrate 64 ms per channel
// - Convert every channel, used or not
// - Start on command or free-running autoconvert
// - Busy flag while converting
// - Previous results readable until sequence ends
// - Results two's complement, 1 C per bit
// - Alarm when at or beyond a limit
// - Standby pin overrides start commands
`ifndef MTS_MAP_VH
`define MTS_MAP_VH

// ****************************************************
// Register offsets
// ****************************************************
`define MTS_OFS_CONFIG    8'h00
`define MTS_OFS_START     8'h01
`define MTS_OFS_STATUS    8'h02
`define MTS_OFS_INT_STAT  8'h03
`define MTS_OFS_INT_MASK  8'h04
`define MTS_OFS_SLV_ADDR  8'h05
`define MTS_GRP_DATA      4'h1
`define MTS_GRP_HIGH      4'h2
`define MTS_GRP_LOW       4'h3

// ****************************************************
// Field positions
// ****************************************************
`define MTS_CFG_STOP      0
`define MTS_CFG_AUTO      1
`define MTS_ST_BUSY       0
`define MTS_ST_STANDBY_PIN_N       1
`define MTS_ST_ALARM      2
`define MTS_ST_SDATA      3
`define MTS_INT_DONE      0
`define MTS_INT_HIGH      1
`define MTS_INT_LOW       2
`define MTS_INT_LINK      3

// ****************************************************
// Reset values
// ****************************************************
`define MTS_RST_CONFIG    8'h00
`define MTS_RST_MASK      4'h0
`define MTS_RST_HIGH      8'h7f
`define MTS_RST_LOW       8'hc9
`define MTS_RST_ADDR_BASE 5'h0a

// ****************************************************
// Timing
// ****************************************************
`define MTS_INTEG_MS      64
`define MTS_CLK_KHZ       50000

`endif

// ---- hdl/mts_sync2.v ----
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Inputs are asynchronous to clk
// Notes:   Only the second stage leaves the module
module mts_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset,
  // Levels
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ---- hdl/mts_seq.v ----
// Purpose: Conversion sequencer, result store and alarm logic
// Assumes: Analog front end delivers adc_result on clk domain
// Notes:   Serial bus protocol lives outside; pins are only watched
//
// Added by the designer: the plain strobed port and the register offsets.
`include "mts_map.vh"
module mts_seq #(
  parameter NUM_CH       = 5,
  parameter CW           = 22,
  parameter INTEG_CYCLES = `MTS_INTEG_MS * `MTS_CLK_KHZ
) (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  // Pins
  input  wire       addr_select_lo,
  input  wire       addr_select_hi,
  input  wire       standby_pin_n,
  input  wire       serial_clock_pin,
  input  wire       serial_data_pin_in,
  output reg        serial_data_pin_out_q,
  output reg        serial_data_pin_oe_q,
  output reg        alert_pin_out_q,
  output reg        alert_pin_oe_q,
  // Converter front end
  input  wire [7:0] adc_result,
  output reg  [2:0] adc_chan_q,
  output reg        adc_integrate_q,
  // Status outputs
  output reg  [6:0] slave_addr_q,
  output reg        irq_q
);

  // ****************************************************
  // Constants and state codes
  // ****************************************************
  // Full-width end points, cut to the counter widths on purpose
  localparam [31:0]   LAST_CNT_W = INTEG_CYCLES - 1;
  localparam [31:0]   LAST_CH_W  = NUM_CH - 1;
  localparam [CW-1:0] LAST_CNT   = LAST_CNT_W[CW-1:0];
  localparam [2:0]    LAST_CH    = LAST_CH_W[2:0];
  localparam [1:0] S_IDLE  = 2'd0;
  localparam [1:0] S_INTEG = 2'd1;
  localparam [1:0] S_CMT   = 2'd2;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  wire [4:0] pins_s;

  mts_sync2 #(
    .W (5)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({serial_data_pin_in, serial_clock_pin, standby_pin_n,
             addr_select_hi, addr_select_lo}),
    .q     (pins_s)
  );

  wire sel_lo_s = pins_s[0];
  wire sel_hi_s = pins_s[1];
  wire run_pin  = pins_s[2];
  wire sclk_s   = pins_s[3];
  wire sdat_s   = pins_s[4];

  // ****************************************************
  // Storage
  // ****************************************************
  reg [7:0]    data_q  [0:NUM_CH-1];
  reg [7:0]    shad_q  [0:NUM_CH-1];
  reg [7:0]    high_q  [0:NUM_CH-1];
  reg [7:0]    low_q   [0:NUM_CH-1];
  reg [NUM_CH-1:0] hi_flag_q;
  reg [NUM_CH-1:0] lo_flag_q;
  reg [7:0]    cfg_q;
  reg [3:0]    int_q;
  reg [3:0]    mask_q;
  reg [1:0]    state_q;
  reg [2:0]    chan_q;
  reg [CW-1:0] cnt_q;
  reg          busy_q;
  reg          sclk_d1_q;
  reg [1:0]    pwr_cnt_q;
  reg          addr_done_q;
  integer      i;
  integer      j;
  integer      k;

  // ****************************************************
  // Decode
  // ****************************************************
  wire [3:0] grp   = reg_addr[7:4];
  wire [2:0] idx   = reg_addr[2:0];
  wire       idx_ok = (reg_addr[3] == 1'b0) && (idx < NUM_CH);
  wire wr_start = reg_wr && (reg_addr == `MTS_OFS_START);
  wire wr_cfg   = reg_wr && (reg_addr == `MTS_OFS_CONFIG);
  wire wr_mask  = reg_wr && (reg_addr == `MTS_OFS_INT_MASK);
  wire wr_int   = reg_wr && (reg_addr == `MTS_OFS_INT_STAT);
  wire wr_high  = reg_wr && (grp == `MTS_GRP_HIGH) && idx_ok;
  wire wr_low   = reg_wr && (grp == `MTS_GRP_LOW) && idx_ok;

  // Standby from pin low or software stop bit
  wire standby = ~run_pin | cfg_q[`MTS_CFG_STOP];
  // Pin or software standby blocks every start
  wire start = !standby && (wr_start || cfg_q[`MTS_CFG_AUTO]);
  // Standby while integrating drops the running sequence
  wire abort = (state_q == S_INTEG) && standby;

  // Alarm comparison on the just-completed sequence
  reg [NUM_CH-1:0] hi_hit;
  reg [NUM_CH-1:0] lo_hit;

  always @* begin
    hi_hit = {NUM_CH{1'b0}};
    lo_hit = {NUM_CH{1'b0}};
    for (i = 0; i < NUM_CH; i = i + 1) begin
      // Signed compare, at or beyond the limit counts
      hi_hit[i] = $signed(shad_q[i]) >= $signed(high_q[i]);
      lo_hit[i] = $signed(shad_q[i]) <= $signed(low_q[i]);
    end
  end

  // ****************************************************
  // Event sources
  // ****************************************************
  wire cmt = (state_q == S_CMT);
  // Result of the current channel is due on this cycle
  wire take = (state_q == S_INTEG) && !standby && (cnt_q == LAST_CNT);
  // The clock pin climbs out of the synchroniser reset value; that
  // first rise is no bus edge, so wait until the pins have settled
  wire link_rise = sclk_s & ~sclk_d1_q & addr_done_q;
  // Pending unmasked events drive both the level and the alarm pin
  wire irq_src = |(int_q & mask_q);

  wire [3:0] ev;
  assign ev[`MTS_INT_DONE] = cmt;
  assign ev[`MTS_INT_HIGH] = cmt && (|hi_hit);
  assign ev[`MTS_INT_LOW]  = cmt && (|lo_hit);
  assign ev[`MTS_INT_LINK] = link_rise;

  // ****************************************************
  // Address capture at power-up
  // ****************************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pwr_cnt_q    <= 2'd0;
      addr_done_q  <= 1'b0;
      slave_addr_q <= 7'h00;
    end else if (!addr_done_q) begin
      pwr_cnt_q <= pwr_cnt_q + 2'd1;
      if (pwr_cnt_q == 2'd3) begin
        // Wait out the synchroniser, then freeze the pins
        addr_done_q  <= 1'b1;
        slave_addr_q <= {`MTS_RST_ADDR_BASE, sel_hi_s, sel_lo_s};
      end
    end
  end

  // ****************************************************
  // Control registers and interrupts
  // ****************************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_q     <= `MTS_RST_CONFIG;
      mask_q    <= `MTS_RST_MASK;
      int_q     <= 4'h0;
      irq_q     <= 1'b0;
      sclk_d1_q <= 1'b0;
    end else begin
      sclk_d1_q <= sclk_s;
      if (wr_cfg)
        cfg_q <= reg_wdata;
      if (wr_mask)
        mask_q <= reg_wdata[3:0];
      // A new event wins over a write-one clear
      int_q <= (int_q & ~(wr_int ? reg_wdata[3:0] : 4'h0)) | ev;
      irq_q <= irq_src;
    end
  end

  // ****************************************************
  // Pins: open-drain outputs never drive high
  // ****************************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      alert_pin_out_q       <= 1'b0;
      alert_pin_oe_q        <= 1'b0;
      serial_data_pin_out_q <= 1'b0;
      serial_data_pin_oe_q  <= 1'b0;
    end else begin
      alert_pin_out_q       <= 1'b0;
      // Pull the alarm line low while an unmasked event waits
      alert_pin_oe_q        <= irq_src;
      // Data line is always released; nothing here ever drives it
      serial_data_pin_out_q <= 1'b0;
      serial_data_pin_oe_q  <= 1'b0;
    end
  end

  // ****************************************************
  // Limit registers
  // ****************************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (j = 0; j < NUM_CH; j = j + 1) begin
        high_q[j] <= `MTS_RST_HIGH;
        low_q[j]  <= `MTS_RST_LOW;
      end
    end else begin
      // Only the host changes limits, standby or not
      if (wr_high)
        high_q[idx] <= reg_wdata;
      if (wr_low)
        low_q[idx] <= reg_wdata;
    end
  end

  // ****************************************************
  // Conversion sequencer
  // ****************************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q         <= S_IDLE;
      chan_q          <= 3'd0;
      cnt_q           <= {CW{1'b0}};
      busy_q          <= 1'b0;
      adc_chan_q      <= 3'd0;
      adc_integrate_q <= 1'b0;
    end else begin
      // Busy spans every channel plus the one-cycle commit
      case (state_q)
        S_IDLE: begin
          // Pin standby overrides any start command
          if (start) begin
            state_q         <= S_INTEG;
            chan_q          <= 3'd0;
            cnt_q           <= {CW{1'b0}};
            busy_q          <= 1'b1;
            adc_chan_q      <= 3'd0;
            adc_integrate_q <= 1'b1;
          end
        end
        S_INTEG: begin
          if (abort) begin
            // Drop the sequence, shadow results are discarded
            state_q         <= S_IDLE;
            busy_q          <= 1'b0;
            adc_integrate_q <= 1'b0;
          end else if (cnt_q == LAST_CNT) begin
            cnt_q <= {CW{1'b0}};
            if (chan_q == LAST_CH) begin
              state_q         <= S_CMT;
              adc_integrate_q <= 1'b0;
            end else begin
              // Every channel is converted, used or not
              chan_q     <= chan_q + 3'd1;
              adc_chan_q <= chan_q + 3'd1;
            end
          end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
          end
        end
        S_CMT: begin
          state_q <= S_IDLE;
          busy_q  <= 1'b0;
        end
        default: begin
          state_q <= S_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************
  // Result capture and commit
  // ****************************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (k = 0; k < NUM_CH; k = k + 1) begin
        shad_q[k] <= 8'h00;
        data_q[k] <= 8'h00;
      end
      hi_flag_q <= {NUM_CH{1'b0}};
      lo_flag_q <= {NUM_CH{1'b0}};
    end else begin
      // Eight-bit result taken at the end of integration
      if (take)
        shad_q[chan_q] <= adc_result;
      // Visible data changes only when a sequence completes
      if (cmt) begin
        for (k = 0; k < NUM_CH; k = k + 1)
          data_q[k] <= shad_q[k];
        hi_flag_q <= hi_hit;
        lo_flag_q <= lo_hit;
      end
    end
  end

  // ****************************************************
  // Read port
  // ****************************************************
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    case (reg_addr)
      `MTS_OFS_CONFIG:   rd_mux = cfg_q;
      `MTS_OFS_STATUS: begin
        rd_mux[`MTS_ST_BUSY]  = busy_q;
        rd_mux[`MTS_ST_STANDBY_PIN_N]  = standby;
        rd_mux[`MTS_ST_ALARM] = |{hi_flag_q, lo_flag_q};
        rd_mux[`MTS_ST_SDATA] = sdat_s;
      end
      `MTS_OFS_INT_STAT: rd_mux = {4'h0, int_q};
      `MTS_OFS_INT_MASK: rd_mux = {4'h0, mask_q};
      `MTS_OFS_SLV_ADDR: rd_mux = {1'b0, slave_addr_q};
      default: begin
        if (idx_ok) begin
          case (grp)
            `MTS_GRP_DATA: rd_mux = data_q[idx];
            `MTS_GRP_HIGH: rd_mux = high_q[idx];
            `MTS_GRP_LOW:  rd_mux = low_q[idx];
            default:       rd_mux = 8'h00;
          endcase
        end
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
      reg_rdata_q <= rd_mux;
    else
      reg_rdata_q <= 8'h00;
  end

endmodule

// ---- sim/mts_seq_properties.sv ----
// Purpose: Concurrent checks on the sequencer ports
// Assumes: Bound onto every mts_seq instance
// Notes:   Channel count follows the bound instance
module mts_seq_props #(
  parameter NUM_CH = 5
) (
  // Clock and reset
  input logic       clk,
  input logic       reset,
  // Pins
  input logic       standby_pin_n,
  input logic       serial_data_pin_out_q,
  input logic       alert_pin_out_q,
  input logic       alert_pin_oe_q,
  // Converter and status
  input logic [2:0] adc_chan_q,
  input logic       adc_integrate_q,
  input logic [6:0] slave_addr_q,
  input logic       irq_q
);
  logic [2:0] age_q;

  // Counts edges since reset so the captured address has settled
  always @(posedge clk or posedge reset) begin
    if (reset) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end

  // ****************************************************
  // Properties
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_first;
    $rose(adc_integrate_q);
  endsequence
  sequence s_step;
    adc_integrate_q && $past(adc_integrate_q) && $changed(adc_chan_q);
  endsequence
  AST_DATA_REL: assert property (!serial_data_pin_out_q)
    else $error("data pin driven high");
  AST_ALERT_OD: assert property (!alert_pin_out_q)
    else $error("alert pin driven high");
  AST_IRQ_PIN: assert property (irq_q == alert_pin_oe_q)
    else $error("alert pin and interrupt disagree");
  AST_FIRST_CH: assert property (s_first |-> adc_chan_q == 3'h0)
    else $error("sequence does not begin at channel 0");
  AST_CH_STEP: assert property (s_step |->
    adc_chan_q == $past(adc_chan_q) + 3'h1)
    else $error("channel skipped");
  AST_CH_RANGE: assert property (adc_integrate_q |->
    adc_chan_q < NUM_CH)
    else $error("channel out of range");
  AST_STANDBY_PIN_N: assert property (!standby_pin_n [*5] |->
    !adc_integrate_q)
    else $error("converting in standby");
  AST_ADDR_HOLD: assert property (age_q == 3'h7 |->
    $stable(slave_addr_q))
    else $error("slave address changed");
endmodule

bind mts_seq mts_seq_props #(.NUM_CH(NUM_CH)) i_props (
  .clk                   (clk),
  .reset                 (reset),
  .standby_pin_n         (standby_pin_n),
  .serial_data_pin_out_q (serial_data_pin_out_q),
  .alert_pin_out_q       (alert_pin_out_q),
  .alert_pin_oe_q        (alert_pin_oe_q),
  .adc_chan_q            (adc_chan_q),
  .adc_integrate_q       (adc_integrate_q),
  .slave_addr_q          (slave_addr_q),
  .irq_q                 (irq_q)
);

// ---- sim/mts_host.sv ----
// Purpose: Host bus master driving the two-wire pins
// Assumes: Data wire has a pull-up; clock idles high
// Notes:   Clock runs only inside a frame
module mts_host (
  // Pins
  output logic scl,
  output logic sda,
  input  logic dut_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pull = 1'b0;

  assign sda = (pull || dut_oe) ? 1'b0 : 1'b1;
  initial scl = 1'b1;

  // Start, eight bits MSB first, stop; 160 ns bit period
  task automatic frame(input logic [7:0] b);
    // Keep every pin change clear of the bench clock edge
    #5 pull = 1'b1;
    #40 scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #20 pull = !b[i];
      #60 scl = 1'b1;
      #80 scl = 1'b0;
    end
    #20 pull = 1'b1;
    #60 scl = 1'b1;
    #40 pull = 1'b0;
  endtask
endmodule

// ---- sim/mts_seq_tb.sv ----
// Purpose: Self-checking bench of the conversion sequencer
// Assumes: Short integration count keeps runs brief
// Notes:   Converter result is a per-channel table
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module mts_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NCH = 5;
  logic       clk = 1'b0, reset = 1'b1, standby_pin_n_n = 1'b1;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, lo = 1'b1, hi = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, adc = 8'h00, rdata;
  logic [7:0] tbl [0:4] = '{8'h19, 8'h50, 8'hf6, 8'h00, 8'h30};
  logic       scl, sda, sd_oe, irq, alert;
  logic [7:0] rdq;
  logic [2:0] chan;
  logic [6:0] saddr;
  int         fail_count = 0, n_tests = 0, cyc = 0;

  mts_seq #(.NUM_CH(NCH), .INTEG_CYCLES(8)) i_dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdq),
    .addr_select_lo(lo), .addr_select_hi(hi), .standby_pin_n(standby_pin_n_n),
    .serial_clock_pin(scl), .serial_data_pin_in(sda),
    .serial_data_pin_out_q(), .serial_data_pin_oe_q(sd_oe),
    .alert_pin_out_q(), .alert_pin_oe_q(alert), .adc_result(adc),
    .adc_chan_q(chan), .adc_integrate_q(), .slave_addr_q(saddr),
    .irq_q(irq));
  mts_host i_host (.scl(scl), .sda(sda), .dut_oe(sd_oe));

  initial forever #10 clk = ~clk;
  always @(posedge clk) adc <= tbl[chan];
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  // ****************************************************
  // Bus tasks
  // ****************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdata = rdq;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK($sformatf("reg %h", a), e, rdata)
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    rd(8'h02);
    while (rdata[0] !== 1'b0 && n < 100) begin
      n++;
      rd(8'h02);
    end
    `CHK("idle", 1'b0, rdata[0])
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("addr", {5'h0a, 1'b0, 1'b1}, saddr)
    lo <= 1'b0;
    hi <= 1'b1;
    for (int c = 0; c < NCH; c++) begin
      rdc(8'h20 + c, 8'h7f);
      rdc(8'h30 + c, 8'hc9);
      rdc(8'h10 + c, 8'h00);
    end
    rdc(8'h7f, 8'h00);
    rdc(8'h05, 8'h29);
    `CHK("addr kept", {5'h0a, 1'b0, 1'b1}, saddr)
    wr(8'h04, 8'h0f);
    wr(8'h01, 8'h00);
    rd(8'h02);
    `CHK("busy", 1'b1, rdata[0])
    rdc(8'h11, 8'h00);
    wait_idle();
    for (int c = 0; c < NCH; c++) rdc(8'h10 + c, tbl[c]);
    rdc(8'h03, 8'h01);
    `CHK("irq", 1'b1, irq)
    `CHK("alert", 1'b1, alert)
    wr(8'h03, 8'h01);
    rdc(8'h03, 8'h00);
    `CHK("irq", 1'b0, irq)
    `CHK("alert", 1'b0, alert)
    wr(8'h21, 8'h50);
    wr(8'h32, 8'hf6);
    wr(8'h01, 8'h00);
    wait_idle();
    rdc(8'h03, 8'h07);
    wr(8'h04, 8'h00);
    rd(8'h02);
    `CHK("masked", 1'b0, irq)
    `CHK("alarm", 1'b1, rdata[2])
    wr(8'h04, 8'h0f);
    wr(8'h03, 8'h07);
    tbl[0] = 8'h11;
    tbl[1] = 8'h44;
    wr(8'h01, 8'h00);
    repeat (7) @(posedge clk);
    #1 `CHK("ch0", 3'h0, chan)
    @(posedge clk);
    #1 `CHK("ch1", 3'h1, chan)
    repeat (4) @(posedge clk);
    standby_pin_n_n <= 1'b0;
    repeat (6) @(posedge clk);
    rd(8'h02);
    `CHK("abort", 1'b0, rdata[0])
    rdc(8'h11, 8'h50);
    rdc(8'h03, 8'h00);
    rdc(8'h21, 8'h50);
    wr(8'h01, 8'h00);
    rd(8'h02);
    `CHK("standby_pin_n", 2'b10, rdata[1:0])
    standby_pin_n_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h00, 8'h02);
    rd(8'h02);
    `CHK("auto", 1'b1, rdata[0])
    wr(8'h00, 8'h00);
    wait_idle();
    rdc(8'h10, 8'h11);
    rdc(8'h11, 8'h44);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h01);
    rd(8'h02);
    `CHK("swstop", 2'b10, rdata[1:0])
    wr(8'h00, 8'h00);
    rdc(8'h10, 8'h11);
    wr(8'h03, 8'h0f);
    i_host.frame(8'ha5);
    rdc(8'h03, 8'h08);
    rd(8'h02);
    `CHK("sda", 1'b1, rdata[3])
    end_sim();
  end
endmodule
